// [logic/iab_cycle_timer.sv]
// Free-running timer that marks the end of each monitoring cycle.
`timescale 1ns/1ps
module iab_cycle_timer #(
    parameter int unsigned PERIOD_CLKS = iab_pkg::IAB_MON_CYCLE_CLKS
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Cycle end pulse.
    output logic tick_r
);
    import iab_pkg::*;
    localparam int CW = $clog2(PERIOD_CLKS + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CLKS - 1);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CW'(1);
            tick_r <= 1'b0;
        end
    end
endmodule : iab_cycle_timer

// [logic/iab_leaky_bucket.sv]
// Leaky-bucket integrator for one monitored reference input.
// What this block does
// (R1) Each input is judged over back-to-back 128 ms monitoring cycles, one update per cycle.
// (R2) A cycle in which the input failed or was erratic adds one to the bucket.
// (R3) Each run of 1, 2, 4 or 8 clean cycles, as programmed, takes one from the bucket.
// (R4) The bucket never rises above the programmed bucket limit.
// (R5) A two-bit leak code picks the 1, 2, 4 or 8 clean-cycle leak period.
// (R6) The alarm is raised when the bucket reaches the limit, and the bucket never drops below 0.
`timescale 1ns/1ps
module iab_leaky_bucket #(
    parameter int unsigned MON_CYCLE_CLKS = iab_pkg::IAB_MON_CYCLE_CLKS
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Monitored input status, level, high while failed or erratic.
    input wire logic input_fault,
    // Configuration registers.
    input wire iab_pkg::iab_count_t activity_bucket_limit,
    input wire logic [iab_pkg::IAB_LEAK_CODE_W-1:0] leak_period_code,
    // Status.
    output iab_pkg::iab_count_t bucket_level_r,
    output logic activity_alarm_r,
    output logic cycle_end_r
);
    import iab_pkg::*;

    logic cycle_tick;
    logic fault_seen_r;
    logic [IAB_LEAK_CNT_W-1:0] clean_cnt_r;
    logic [IAB_LEAK_CNT_W-1:0] leak_len;
    logic cycle_faulty;
    logic leak_due;
    iab_count_t bucket_nxt;

    iab_cycle_timer #(.PERIOD_CLKS(MON_CYCLE_CLKS)) u_timer (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick_r(cycle_tick)
    );

    // Latch any fault seen within the current cycle, including its last clock.
    assign cycle_faulty = fault_seen_r | input_fault;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fault_seen_r <= 1'b0;
        end else if (cycle_tick) begin
            fault_seen_r <= 1'b0; // R1
        end else if (input_fault) begin
            fault_seen_r <= 1'b1;
        end
    end

    // Leak length in clean cycles, encoded as length minus one.
    always_comb begin
        unique case (leak_period_code) // R5
            2'h0: leak_len = IAB_LEAK_LEN_1;
            2'h1: leak_len = IAB_LEAK_LEN_2;
            2'h2: leak_len = IAB_LEAK_LEN_4;
            2'h3: leak_len = IAB_LEAK_LEN_8;
        endcase
    end

    assign leak_due = !cycle_faulty && (clean_cnt_r >= leak_len); // R3

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clean_cnt_r <= IAB_LEAK_CNT_ZERO;
        end else if (cycle_tick) begin
            if (cycle_faulty || leak_due) begin
                clean_cnt_r <= IAB_LEAK_CNT_ZERO; // R3
            end else begin
                clean_cnt_r <= clean_cnt_r + IAB_LEAK_CNT_ONE;
            end
        end
    end

    always_comb begin
        bucket_nxt = bucket_level_r;
        if (cycle_faulty) begin
            if (bucket_level_r < activity_bucket_limit) begin
                bucket_nxt = bucket_level_r + IAB_BUCKET_ONE; // R2
            end else begin
                bucket_nxt = activity_bucket_limit; // R4
            end
        end else if (leak_due && bucket_level_r != IAB_BUCKET_ZERO) begin
            bucket_nxt = bucket_level_r - IAB_BUCKET_ONE; // R6
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bucket_level_r <= IAB_BUCKET_ZERO;
        end else if (cycle_tick) begin
            bucket_level_r <= bucket_nxt; // R1
        end
    end

    // Alarm follows the bucket level; a limit of zero means always alarmed.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            activity_alarm_r <= 1'b0;
        end else begin
            activity_alarm_r <= (bucket_level_r >= activity_bucket_limit); // R6
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cycle_end_r <= 1'b0;
        end else begin
            cycle_end_r <= cycle_tick;
        end
    end

    // Bucket may only move on a cycle boundary.
    a_bucket_steady: assert property (@(posedge ref_clk) disable iff (reset)
        !cycle_tick |=> $stable(bucket_level_r)) // R1
        else $error("bucket changed between cycle boundaries");

    sequence s_fault_tick;
        cycle_tick && cycle_faulty && (bucket_level_r < activity_bucket_limit);
    endsequence

    a_fault_fill: assert property (@(posedge ref_clk) disable iff (reset)
        s_fault_tick |=> (bucket_level_r == $past(bucket_level_r) + IAB_BUCKET_ONE)) // R2
        else $error("faulty cycle did not add one");

    a_clean_leak: assert property (@(posedge ref_clk) disable iff (reset)
        (cycle_tick && leak_due && bucket_level_r != IAB_BUCKET_ZERO)
        |=> (bucket_level_r == $past(bucket_level_r) - IAB_BUCKET_ONE)) // R3
        else $error("leak period did not remove one");

    a_no_early_leak: assert property (@(posedge ref_clk) disable iff (reset)
        (cycle_tick && !cycle_faulty && clean_cnt_r < leak_len)
        |=> (bucket_level_r == $past(bucket_level_r))) // R5
        else $error("bucket leaked before the period ended");

    a_limit_cap: assert property (@(posedge ref_clk) disable iff (reset)
        (cycle_tick && cycle_faulty && bucket_level_r >= activity_bucket_limit)
        |=> (bucket_level_r == $past(activity_bucket_limit))) // R4
        else $error("bucket passed the limit");

    a_alarm_level: assert property (@(posedge ref_clk) disable iff (reset)
        ##1 (activity_alarm_r == ($past(bucket_level_r) >= $past(activity_bucket_limit)))) // R6
        else $error("alarm does not match bucket level");

    a_no_underflow: assert property (@(posedge ref_clk) disable iff (reset)
        (bucket_level_r == IAB_BUCKET_ZERO && !cycle_faulty)
        |=> (bucket_level_r == IAB_BUCKET_ZERO)) // R6
        else $error("bucket wrapped below zero");

    a_tick_period: assert property (@(posedge ref_clk) disable iff (reset)
        cycle_tick |=> !cycle_tick) // R1
        else $error("cycle ticks too close together");

    // Clocks since the last cycle end, kept only for the cycle length check.
    // The first cycle after reset is skipped, as its start is not a tick.
    int unsigned tick_gap_r;
    logic tick_seen_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tick_gap_r <= 32'h0;
            tick_seen_r <= 1'b0;
        end else if (cycle_tick) begin
            tick_gap_r <= 32'h0;
            tick_seen_r <= 1'b1;
        end else begin
            tick_gap_r <= tick_gap_r + 32'h1;
        end
    end

    a_cycle_length: assert property (@(posedge ref_clk) disable iff (reset)
        (cycle_tick && tick_seen_r) |-> (tick_gap_r == MON_CYCLE_CLKS - 32'h1)) // R1
        else $error("monitoring cycle has the wrong length");

    // The cycle end pulse marks exactly the boundary edge.
    a_end_pulse: assert property (@(posedge ref_clk) disable iff (reset)
        cycle_tick |=> cycle_end_r) // R1
        else $error("cycle end pulse missing after boundary");

    a_end_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        !cycle_tick |=> !cycle_end_r) // R1
        else $error("cycle end pulse without boundary");

    // The fault latch holds a fault until the boundary, then starts afresh.
    a_fault_latch: assert property (@(posedge ref_clk) disable iff (reset)
        (!cycle_tick && input_fault) |=> fault_seen_r) // R2
        else $error("fault inside a cycle was not latched");

    a_fault_clear: assert property (@(posedge ref_clk) disable iff (reset)
        cycle_tick |=> !fault_seen_r) // R1
        else $error("fault latch not cleared at boundary");

    // Clean-run counting steps.
    sequence s_clean_tick;
        cycle_tick && !cycle_faulty;
    endsequence

    sequence s_run_step;
        s_clean_tick ##0 !leak_due;
    endsequence

    a_run_restart: assert property (@(posedge ref_clk) disable iff (reset)
        (cycle_tick && cycle_faulty) |=> (clean_cnt_r == IAB_LEAK_CNT_ZERO)) // R3
        else $error("faulty cycle did not restart the clean run");

    a_run_count: assert property (@(posedge ref_clk) disable iff (reset)
        s_run_step |=> (clean_cnt_r == $past(clean_cnt_r) + IAB_LEAK_CNT_ONE)) // R5
        else $error("clean cycle was not counted");

    a_run_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !cycle_tick |=> $stable(clean_cnt_r)) // R3
        else $error("clean run moved between cycle boundaries");
endmodule : iab_leaky_bucket

// [logic/iab_pkg.sv]
// Package with constants and types for the input activity leaky bucket.
package iab_pkg;
    localparam int unsigned IAB_CLK_HZ = 50_000_000;
    localparam int unsigned IAB_MON_CYCLE_MS = 128;
    localparam longint unsigned IAB_MON_CYCLE_CLKS_L =
        (longint'(IAB_MON_CYCLE_MS) * longint'(IAB_CLK_HZ)) / 64'd1000;
    localparam int unsigned IAB_MON_CYCLE_CLKS = int'(IAB_MON_CYCLE_CLKS_L);
    localparam int IAB_BUCKET_W = 8;
    localparam int IAB_LEAK_CODE_W = 2;
    localparam int IAB_LEAK_CNT_W = 3;
    localparam logic [IAB_BUCKET_W-1:0] IAB_BUCKET_ZERO = 8'h00;
    localparam logic [IAB_BUCKET_W-1:0] IAB_BUCKET_ONE = 8'h01;
    localparam logic [IAB_BUCKET_W-1:0] IAB_LIMIT_RESET = 8'h08;
    localparam logic [IAB_LEAK_CODE_W-1:0] IAB_LEAK_CODE_RESET = 2'h1;
    localparam logic [IAB_LEAK_CNT_W-1:0] IAB_LEAK_CNT_ZERO = 3'h0;
    localparam logic [IAB_LEAK_CNT_W-1:0] IAB_LEAK_CNT_ONE = 3'h1;
    localparam logic [IAB_LEAK_CNT_W-1:0] IAB_LEAK_LEN_1 = 3'h0;
    localparam logic [IAB_LEAK_CNT_W-1:0] IAB_LEAK_LEN_2 = 3'h1;
    localparam logic [IAB_LEAK_CNT_W-1:0] IAB_LEAK_LEN_4 = 3'h3;
    localparam logic [IAB_LEAK_CNT_W-1:0] IAB_LEAK_LEN_8 = 3'h7;
    typedef logic [IAB_BUCKET_W-1:0] iab_count_t;
endpackage : iab_pkg

// [verification/iab_ref_model.sv]
// Model of the monitored reference input, failing in short bursts on request.
`timescale 1ns/1ps
module iab_ref_model (
    // Clock.
    input wire logic ref_clk,
    // Burst request and fault status.
    input wire logic fail_req,
    output logic input_fault
);
    logic [1:0] left_r = 2'h0;
    always_ff @(posedge ref_clk) begin
        if (fail_req) begin
            left_r <= 2'h2;
        end else if (left_r != 2'h0) begin
            left_r <= left_r - 2'h1;
        end
    end
    assign input_fault = left_r != 2'h0;
endmodule : iab_ref_model

// [verification/testbench.sv]
// Self-checking testbench for the input activity leaky bucket.
`timescale 1ns/1ps
module testbench;
    import iab_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic fail_req = 1'b0;
    logic input_fault, alarm, cyc_end;
    logic [1:0] code = 2'h0;
    iab_count_t limit = 8'h03;
    iab_count_t level;
    iab_count_t exp_lvl = 8'h00;
    int err_count = 0, checks = 0, run = 0, clks = 0, gap = 0;
    always #10 ref_clk = ~ref_clk;
    iab_ref_model i_iab_ref_model (.ref_clk(ref_clk), .fail_req(fail_req),
        .input_fault(input_fault));
    iab_leaky_bucket #(.MON_CYCLE_CLKS(16)) i_iab_leaky_bucket (.ref_clk(ref_clk),
        .reset(reset), .input_fault(input_fault), .activity_bucket_limit(limit),
        .leak_period_code(code), .bucket_level_r(level), .activity_alarm_r(alarm),
        .cycle_end_r(cyc_end));
    task automatic close_out();
        $display("err_count=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // A wait for a cycle end gives up after 40 clocks, and the whole run is capped at 3000 clocks.
    always @(posedge ref_clk) begin
        clks++;
        if (clks == 3000) begin
            err_count++;
            close_out();
        end
    end
    task automatic cmp_val(input iab_count_t got, input iab_count_t exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t value %h expected %h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic wait_end();
        gap = 0;
        do begin
            @(posedge ref_clk);
            #1;
            gap++;
        end while (cyc_end !== 1'b1 && gap < 40);
        if (gap >= 40) err_count++;
    endtask : wait_end
    task automatic cyc(input logic f);
        @(posedge ref_clk) fail_req <= f;
        @(posedge ref_clk) fail_req <= 1'b0;
        wait_end();
        if (f) begin
            run = 0;
            if (exp_lvl < limit) exp_lvl++;
        end else if (++run == (1 << code)) begin
            run = 0;
            if (exp_lvl != 8'h00) exp_lvl--;
        end
        cmp_val(level, exp_lvl);
        // The alarm follows the level one clock later.
        @(posedge ref_clk);
        #1;
        cmp_val({7'h00, alarm}, {7'h00, exp_lvl >= limit});
    endtask : cyc
    task automatic t_fill();
        repeat (4) cyc(1'b1);
    endtask : t_fill
    task automatic t_leak();
        for (int c = 0; c < 4; c++) begin
            @(posedge ref_clk) code <= c[1:0];
            cyc(1'b1);
            repeat (1 << c) cyc(1'b0);
        end
    endtask : t_leak
    task automatic t_floor();
        @(posedge ref_clk) code <= 2'h0;
        cyc(1'b1);
        repeat (5) cyc(1'b0);
    endtask : t_floor
    task automatic t_period();
        wait_end();
        wait_end();
        cmp_val(gap[7:0], 8'h10);
    endtask : t_period
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        wait_end();
        t_fill();
        t_leak();
        t_floor();
        t_period();
        close_out();
    end
endmodule : testbench
